// *** rtl/light_chan.sv ***
// Purpose: one sensor channel: filter, level flags, conversion sequencer
// Assumes: comparator results are synchronous digital levels
// Notes:   a forced conversion bypasses the filter count
`timescale 1ns/1ns
`include "light_cmp_regs.svh"
module light_chan
(
   // clock and reset
   input  wire logic  clk,
   input  wire logic  sys_rst,
   input  wire logic  ce,
   // register side
   light_chan_if.chan ch
);
   light_cmp_pkg::chan_state_t state_q, state_d;  // sequencer
   logic       dark_q, dark_d;                    // dark flag
   logic       off_q, off_d;                      // office flag
   logic [7:0] cnt_q, cnt_d;                      // disagreeing runs
   logic       forced_q, forced_d;                // conversion was forced
   logic       tgt_dark;                          // wanted dark level
   logic       tgt_off;                           // wanted office level
   logic [7:0] need;                              // measurements needed

   // -------------------------------------------
   // level decision with hysteresis
   // -------------------------------------------
   always_comb
   begin
      // set below trip, clear above trip + hysteresis, else hold
      tgt_dark = ch.input_en & ch.dark_en &                      // R11
                 (dark_q ? !ch.dark_above : ch.dark_below);     // R15
      // dark level implies office level when office is enabled: dark wins
      tgt_off  = ch.input_en & ch.office_en &                    // R12
                 (tgt_dark |                                     // R13
                  (off_q ? !ch.off_above : ch.off_below));      // R14
      need     = 8'h01 << ch.measure_count_sel_sel;                           // R7
   end

   // -------------------------------------------
   // sequencer and filter
   // -------------------------------------------
   always_comb
   begin
      state_d  = state_q;
      dark_d   = dark_q;
      off_d    = off_q;
      cnt_d    = cnt_q;
      forced_d = forced_q;
      case (state_q)
         light_cmp_pkg::ST_IDLE:
         begin
            // slot strobe on an enabled input, or a pending force, starts a conversion
            if (ch.force_req || (ch.tick && ch.input_en))         // R9
            begin
               state_d  = light_cmp_pkg::ST_CONVERT;
               forced_d = ch.force_req;
            end
         end
         light_cmp_pkg::ST_CONVERT:
         begin
            state_d = light_cmp_pkg::ST_DONE;
            if (tgt_dark == dark_q && tgt_off == off_q)
            begin
               // agreement breaks any run of changes
               cnt_d = 8'h00;
            end
            else if (forced_q || (cnt_q + 8'h01) >= need)          // R7
            begin
               dark_d = tgt_dark;
               off_d  = tgt_off;
               cnt_d  = 8'h00;
            end
            else
            begin
               cnt_d = cnt_q + 8'h01;
            end
         end
         light_cmp_pkg::ST_DONE:
         begin
            // flags are valid here, so a force may retire
            state_d  = light_cmp_pkg::ST_IDLE;                    // R10
            forced_d = 1'b0;
         end
         default:
         begin
            state_d = light_cmp_pkg::ST_IDLE;
         end
      endcase
   end

   // registers, frozen while ce is low
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         state_q  <= light_cmp_pkg::ST_IDLE;
         dark_q   <= 1'b0;
         off_q    <= 1'b0;
         cnt_q    <= 8'h00;
         forced_q <= 1'b0;
      end
      else if (ce)
      begin
         state_q  <= state_d;
         dark_q   <= dark_d;
         off_q    <= off_d;
         cnt_q    <= cnt_d;
         forced_q <= forced_d;
      end
   end

   assign ch.dark_flag   = dark_q;
   assign ch.office_flag = off_q;
   assign ch.force_done  = ce && forced_q &&
                           (state_q == light_cmp_pkg::ST_DONE);

   // -------------------------------------------
   // checks
   // -------------------------------------------
   AST_SEQ: assert property (@(posedge clk) disable iff (sys_rst)  // R10
      (ce && state_q == light_cmp_pkg::ST_CONVERT) |=>
      state_q == light_cmp_pkg::ST_DONE)
      else $error("conversion did not reach done");
   AST_PRIO: assert property (@(posedge clk) disable iff (sys_rst)  // R13
      (state_q == light_cmp_pkg::ST_DONE && $changed(dark_q) &&
       dark_q && ch.office_en) |-> off_q)
      else $error("dark level without office level");
   AST_DRK_OFF: assert property (@(posedge clk) disable iff (sys_rst) // R11
      ($changed(dark_q) && dark_q) |-> $past(ch.dark_en))
      else $error("disabled dark comparator set its flag");
   AST_OFF_OFF: assert property (@(posedge clk) disable iff (sys_rst) // R12
      ($changed(off_q) && off_q) |-> $past(ch.office_en))
      else $error("disabled office comparator set its flag");
   AST_FILTER: assert property (@(posedge clk) disable iff (sys_rst) // R7
      ($changed(dark_q) || $changed(off_q)) |->
      ($past(forced_q) || ($past(cnt_q) + 8'h01) >= $past(need)))
      else $error("level changed before filter count");
endmodule

// *** rtl/light_chan_if.sv ***
// Purpose: carrier between register logic and one sensor channel
// Assumes: single clock domain
// Notes:   ctrl side drives config, chan side drives flags
`timescale 1ns/1ns
interface light_chan_if;
   logic       input_en;     // sensor input enabled
   logic       dark_en;      // dark comparator enabled
   logic       office_en;    // office comparator enabled
   logic [2:0] measure_count_sel_sel;     // log2 of agreeing measurements
   logic       tick;         // measurement slot strobe
   logic       force_req;    // forced conversion pending
   logic       dark_below;   // input under dark trip
   logic       dark_above;   // input over dark trip + hysteresis
   logic       off_below;    // input under office trip
   logic       off_above;    // input over office trip + hysteresis
   logic       dark_flag;    // dark level result
   logic       office_flag;  // office level result
   logic       force_done;   // forced conversion finished, pulse
   modport ctrl (output input_en, dark_en, office_en, measure_count_sel_sel, tick,
                 force_req, dark_below, dark_above, off_below, off_above,
                 input dark_flag, office_flag, force_done);
   modport chan (input input_en, dark_en, office_en, measure_count_sel_sel, tick,
                 force_req, dark_below, dark_above, off_below, off_above,
                 output dark_flag, office_flag, force_done);
endinterface

// *** rtl/light_cmp_ctrl.sv ***
// Purpose: comparator status/config registers for two light sensors
// Assumes: register port already decoded from the serial bus
// Notes:   read data appears one cycle after reg_rd
`timescale 1ns/1ns
`include "light_cmp_regs.svh"
//
// Behaviour
// R1 - bit 7: sensor two dark result
// R2 - bit 6: sensor two office result
// R3 - bit 5: sensor one dark result
// R4 - bit 4: sensor one office result
// R5 - bits 3,2: per-sensor interrupt enables
// R6 - bits 1,0: per-sensor input enables
// R7 - filter field: two-power agreeing measurements needed
// R8 - one measurement slot every 0.08 s
// R9 - writing force bit runs one conversion
// R10 - force bit self-clears after flags are valid
// R11 - config bit 1 enables dark comparator
// R12 - config bit 0 enables office comparator
// R13 - dark decision overrides office decision
// R14 - office flag: set below trip, clear above hysteresis
// R15 - dark flag: set below trip, clear above hysteresis
// R16 - enabled flag change raises interrupt
module light_cmp_ctrl
#(
   parameter int MEAS_CYCLES = `LCMP_MEAS_CYCLES  // cycles per slot
)
(
   // clock and reset
   input  wire logic       clk,
   input  wire logic       sys_rst,
   input  wire logic       ce,
   // register port
   input  wire logic [7:0] reg_addr,
   input  wire logic       reg_wr,
   input  wire logic [7:0] reg_wdata,
   input  wire logic       reg_rd,
   output logic      [7:0] reg_rdata,
   // analogue comparator results, index 0 is sensor one
   input  wire logic [1:0] dark_below,
   input  wire logic [1:0] dark_above,
   input  wire logic [1:0] off_below,
   input  wire logic [1:0] off_above,
   // interrupt toward host, one-cycle pulse
   output logic            irq
);
   localparam int TW = $clog2(MEAS_CYCLES + 1);

   // -------------------------------------------
   // parameter check
   // -------------------------------------------
   if (MEAS_CYCLES < 2)
   begin : g_bad_meas
      $error("MEAS_CYCLES must be at least 2");
   end

   logic [3:0]    ctrl_q, ctrl_d;        // ien and input enables
   logic [5:0]    cfg_q [2];             // filter, force, enables
   logic [5:0]    cfg_d [2];
   logic [TW-1:0] tick_q, tick_d;        // slot counter
   logic          slot_q, slot_d;        // slot strobe
   logic [7:0]    rdata_q, rdata_d;      // read answer
   logic          irq_q, irq_d;          // interrupt pulse
   logic [1:0]    dark_v;                // dark flags per sensor
   logic [1:0]    off_v;                 // office flags per sensor
   logic [1:0]    fdone_v;               // force retire pulses
   logic [1:0]    dark_p_q, dark_p_d;    // flags last cycle
   logic [1:0]    off_p_q, off_p_d;
   logic [7:0]    status;                // assembled status byte
   logic [7:0]    cfg_addr [2];          // config offsets

   assign cfg_addr[0] = `LCMP_S1_CFG_OFS;
   assign cfg_addr[1] = `LCMP_S2_CFG_OFS;

   // -------------------------------------------
   // sensor channels
   // -------------------------------------------
   for (genvar i = 0; i < 2; i++)
   begin : g_ch
      light_chan_if ch ();
      assign ch.input_en   = ctrl_q[`LCMP_INEN_POS + i];            // R6
      assign ch.dark_en    = cfg_q[i][`LCMP_DRK_EN_POS];            // R11
      assign ch.office_en  = cfg_q[i][`LCMP_OFF_EN_POS];            // R12
      assign ch.measure_count_sel_sel   = cfg_q[i][`LCMP_MEASURE_COUNT_SEL_HI:`LCMP_MEASURE_COUNT_SEL_LO]; // R7
      assign ch.tick       = slot_q;                                // R8
      assign ch.force_req  = cfg_q[i][`LCMP_FORCE_POS];             // R9
      assign ch.dark_below = dark_below[i];
      assign ch.dark_above = dark_above[i];
      assign ch.off_below  = off_below[i];
      assign ch.off_above  = off_above[i];
      assign dark_v[i]     = ch.dark_flag;
      assign off_v[i]      = ch.office_flag;
      assign fdone_v[i]    = ch.force_done;
      light_chan u_chan
      (
         .clk     (clk),
         .sys_rst (sys_rst),
         .ce      (ce),
         .ch      (ch)
      );
   end

   // status byte: flags high, enables low
   always_comb
   begin
      status = {dark_v[1], off_v[1], dark_v[0], off_v[0],   // R1 R2 R3 R4
                ctrl_q};                                    // R5 R6
   end

   // -------------------------------------------
   // measurement slot timer
   // -------------------------------------------
   always_comb
   begin
      // a long slot keeps conversions rare and power low
      slot_d = 1'b0;
      tick_d = tick_q + TW'(1);
      if (tick_q == TW'(MEAS_CYCLES - 1))
      begin
         tick_d = '0;
         slot_d = 1'b1;                                            // R8
      end
   end

   // -------------------------------------------
   // register writes, reads and interrupt
   // -------------------------------------------
   always_comb
   begin
      ctrl_d   = ctrl_q;
      rdata_d  = rdata_q;
      dark_p_d = dark_v;
      off_p_d  = off_v;
      // a change on an enabled sensor gives one pulse
      irq_d    = |(((dark_v ^ dark_p_q) | (off_v ^ off_p_q)) &
                   ctrl_q[`LCMP_IEN_POS +: 2]);                    // R16
      if (reg_wr && reg_addr == `LCMP_STATUS_OFS)
      begin
         // flag bits are read-only
         ctrl_d = reg_wdata[3:0];                                  // R5 R6
      end
      for (int k = 0; k < 2; k++)
      begin
         cfg_d[k] = cfg_q[k];
         if (fdone_v[k])
         begin
            cfg_d[k][`LCMP_FORCE_POS] = 1'b0;                      // R10
         end
         // a write landing with the retire wins, so a new force stays
         if (reg_wr && reg_addr == cfg_addr[k])
         begin
            cfg_d[k] = reg_wdata[5:0];                             // R9
         end
      end
      if (reg_rd)
      begin
         // unmapped offsets and unused bits read zero
         rdata_d = 8'h00;
         if (reg_addr == `LCMP_STATUS_OFS)
         begin
            rdata_d = status;                                      // R1
         end
         else if (reg_addr == cfg_addr[0])
         begin
            rdata_d = {2'b00, cfg_q[0]};
         end
         else if (reg_addr == cfg_addr[1])
         begin
            rdata_d = {2'b00, cfg_q[1]};
         end
      end
   end

   // state registers, frozen while ce is low
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         ctrl_q   <= `LCMP_STATUS_RST;
         cfg_q[0] <= `LCMP_CFG_RST;
         cfg_q[1] <= `LCMP_CFG_RST;
         tick_q   <= '0;
         slot_q   <= 1'b0;
         rdata_q  <= 8'h00;
         irq_q    <= 1'b0;
         dark_p_q <= 2'b00;
         off_p_q  <= 2'b00;
      end
      else if (ce)
      begin
         ctrl_q   <= ctrl_d;
         cfg_q[0] <= cfg_d[0];
         cfg_q[1] <= cfg_d[1];
         tick_q   <= tick_d;
         slot_q   <= slot_d;
         rdata_q  <= rdata_d;
         irq_q    <= irq_d;
         dark_p_q <= dark_p_d;
         off_p_q  <= off_p_d;
      end
   end

   assign reg_rdata = rdata_q;
   assign irq       = irq_q;

   // -------------------------------------------
   // checks
   // -------------------------------------------
   AST_FORCE_CLR: assert property (@(posedge clk) disable iff (sys_rst) // R10
      (ce && fdone_v[0] && !(reg_wr && reg_addr == `LCMP_S1_CFG_OFS)) |=>
      !cfg_q[0][`LCMP_FORCE_POS])
      else $error("force bit not cleared after conversion");
   AST_FORCE_HOLD: assert property (@(posedge clk) disable iff (sys_rst) // R9
      (ce && cfg_q[1][`LCMP_FORCE_POS] && !fdone_v[1] && !reg_wr) |=>
      cfg_q[1][`LCMP_FORCE_POS])
      else $error("force bit dropped before conversion ended");
   AST_RD_STAT: assert property (@(posedge clk) disable iff (sys_rst) // R2
      (ce && reg_rd && reg_addr == `LCMP_STATUS_OFS) |=>
      reg_rdata == {$past(dark_v[1]), $past(off_v[1]),
                    $past(dark_v[0]), $past(off_v[0]), $past(ctrl_q)})
      else $error("status read does not match flags");
   AST_CTRL_WR: assert property (@(posedge clk) disable iff (sys_rst) // R5
      (ce && reg_wr && reg_addr == `LCMP_STATUS_OFS) ##1
      (ce && reg_rd && !reg_wr && reg_addr == `LCMP_STATUS_OFS) |=>
      reg_rdata[3:0] == $past(reg_wdata[3:0], 2))
      else $error("enable bits not written");
   AST_IRQ: assert property (@(posedge clk) disable iff (sys_rst) // R16
      (ce && $changed(dark_v[0]) && ctrl_q[`LCMP_IEN_POS]) |=> irq)
      else $error("enabled flag change without interrupt");
   AST_NO_IRQ: assert property (@(posedge clk) disable iff (sys_rst) // R16
      (ce && ctrl_q[`LCMP_IEN_POS +: 2] == 2'b00) |=> !irq)
      else $error("interrupt while both sensors masked");
   AST_TICK: assert property (@(posedge clk) disable iff (sys_rst) // R8
      $rose(slot_q) |-> $past(tick_q) == TW'(MEAS_CYCLES - 1))
      else $error("slot strobe off period");
endmodule

// *** rtl/light_cmp_pkg.sv ***
// Purpose: shared types of the light comparator block
// Assumes: nothing
// Notes:   constants live in light_cmp_regs.svh
package light_cmp_pkg;
   // conversion sequencer, one-hot
   typedef enum logic [2:0]
   {
      ST_IDLE    = 3'h1,
      ST_CONVERT = 3'h2,
      ST_DONE    = 3'h4
   } chan_state_t;
endpackage

// *** rtl/light_cmp_regs.svh ***
// Purpose: register map, field positions and timing of the light comparators
// Assumes: 8-bit registers on the device's own register port
// Notes:   definitions only
`ifndef LIGHT_CMP_REGS_SVH
`define LIGHT_CMP_REGS_SVH
// offsets
`define LCMP_STATUS_OFS   8'h30
`define LCMP_S1_CFG_OFS   8'h31
`define LCMP_S2_CFG_OFS   8'h32
// reset values
`define LCMP_STATUS_RST   4'h0
`define LCMP_CFG_RST      6'h00
// status register fields, sensor n adds n (flags add 2n)
`define LCMP_OFF_FLAG_POS 4
`define LCMP_DRK_FLAG_POS 5
`define LCMP_IEN_POS      2
`define LCMP_INEN_POS     0
// sensor config fields
`define LCMP_MEASURE_COUNT_SEL_HI      5
`define LCMP_MEASURE_COUNT_SEL_LO      3
`define LCMP_FORCE_POS    2
`define LCMP_DRK_EN_POS   1
`define LCMP_OFF_EN_POS   0
// timing: one measurement slot
`define LCMP_MEAS_TIME_NS 80000000
`define LCMP_CLK_NS       4
`define LCMP_MEAS_CYCLES  (`LCMP_MEAS_TIME_NS / `LCMP_CLK_NS)
`endif

// *** verification/light_cmp_ctrl_test.sv ***
// Purpose: self-checking bench of the light comparator registers
// Assumes: short slot period, sensor model on the comparator pins
// Notes:   drives at the falling edge, random draws from a fixed seed
`timescale 1ns/1ns
module light_cmp_ctrl_test;
   localparam int MC = 10;   // cycles per slot, shortened
   localparam int DT = 40;   // dark trip
   localparam int DH = 10;   // dark hysteresis
   localparam int OT = 120;  // office trip
   localparam int OH = 20;   // office hysteresis
   logic        clk;           // 4 ns clock
   logic        sys_rst;       // sync reset
   logic        ce;            // clock enable
   logic [7:0]  reg_addr;      // register offset
   logic        reg_wr;        // write strobe
   logic [7:0]  reg_wdata;     // write data
   logic        reg_rd;        // read strobe
   logic [7:0]  reg_rdata;     // read answer
   logic [1:0]  dark_below;    // comparator levels
   logic [1:0]  dark_above;
   logic [1:0]  off_below;
   logic [1:0]  off_above;
   logic        irq;           // interrupt pulse
   logic [15:0] light;         // sensor two in upper byte
   logic [31:0] seed;          // xorshift state
   logic [1:0]  exp_d;         // modelled dark flags
   logic [1:0]  exp_o;         // modelled office flags
   int          mismatches;    // failed compares
   int          total_checks;  // all compares
   int          irq_cnt;       // pulses seen

   light_cmp_ctrl #(.MEAS_CYCLES(MC)) uut
   (
      .clk(clk), .sys_rst(sys_rst), .ce(ce),
      .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .dark_below(dark_below), .dark_above(dark_above),
      .off_below(off_below), .off_above(off_above), .irq(irq)
   );
   light_sensor_model #(.DARK_TRIP(DT), .DARK_HYS(DH),
                        .OFF_TRIP(OT), .OFF_HYS(OH)) sensors
   (
      .light(light), .dark_below(dark_below), .dark_above(dark_above),
      .off_below(off_below), .off_above(off_above)
   );

   // ------------------------------------------------------------
   // clock, interrupt counter, watchdog
   // ------------------------------------------------------------
   initial
   begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   // pulse is one cycle, so count it on the edge
   always @(posedge clk)
   begin
      if (irq === 1'b1)
         irq_cnt <= irq_cnt + 1;
   end
   // tests need about 700 cycles; allow nearly thirty times that
   initial
   begin
      #(20000 * 4);
      mismatches++;
      print_verdict;
   end

   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction
   // one conversion: returns {dark, office}
   function automatic logic [1:0] conv(input logic [7:0] l,
      input logic [1:0] en, input logic inen, input logic pd,
      input logic po);
      logic dt;
      logic ot;
      dt = 1'b0;
      ot = 1'b0;
      if (inen && en[1])
         dt = (l < DT) ? 1'b1 : (l > DT + DH) ? 1'b0 : pd;
      if (inen && en[0])
         ot = (dt || l < OT) ? 1'b1 : (l > OT + OH) ? 1'b0 : po;
      return {dt, ot};
   endfunction
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk);
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      @(negedge clk);
      reg_wr = 1'b0;
   endtask
   // answer is registered, settled by the next falling edge
   task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
      @(negedge clk);
      reg_addr = a;
      reg_rd = 1'b1;
      @(negedge clk);
      reg_rd = 1'b0;
      check(reg_rdata, exp);
   endtask
   task automatic do_reset;
      @(negedge clk);
      sys_rst = 1'b1;
      repeat (3) @(negedge clk);
      sys_rst = 1'b0;
      exp_d = 2'b00;
      exp_o = 2'b00;
   endtask
   // forced conversion of sensor s; filter 7 keeps slots from acting
   task automatic force_chk(input int s, input logic [7:0] l,
                            input logic [1:0] en, input logic [3:0] nib);
      logic [1:0] r;
      int         n0;
      light[s*8 +: 8] = l;
      wr_reg(8'h30, {4'h0, nib});
      r = conv(l, en, nib[s], exp_d[s], exp_o[s]);
      n0 = irq_cnt;
      wr_reg(8'(8'h31 + s), {2'b11, 3'h7, 1'b1, en});
      rd_chk(8'(8'h31 + s), {6'h0F, en});
      repeat (6) @(negedge clk);
      rd_chk(8'(8'h31 + s), {6'h0E, en});
      check(8'(irq_cnt - n0),
            8'((r != {exp_d[s], exp_o[s]}) && nib[2+s]));
      exp_d[s] = r[1];
      exp_o[s] = r[0];
      rd_chk(8'h30, {exp_d[1], exp_o[1], exp_d[0], exp_o[0], nib});
   endtask
   // sensor one dark; flags must wait for 2**code slots
   task automatic measure_count_sel_chk(input logic [2:0] code);
      do_reset;
      light = 16'h0000;
      wr_reg(8'h31, {2'b00, code, 3'b011});
      wr_reg(8'h30, 8'h01);
      if (code != 3'h0)
      begin
         repeat (((1 << code) - 1) * MC - 2) @(negedge clk);
         rd_chk(8'h30, 8'h01);
      end
      repeat (2 * MC) @(negedge clk);
      rd_chk(8'h30, 8'h31);
      $display("filter code %0d done", code);
   endtask
   task automatic print_verdict;
      $display("checks %0d, mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial
   begin
      sys_rst = 1'b1;
      ce = 1'b1;
      reg_addr = 8'h00;
      reg_wr = 1'b0;
      reg_wdata = 8'h00;
      reg_rd = 1'b0;
      light = 16'hFFFF;
      seed = 32'h57AB;
      mismatches = 0;
      total_checks = 0;
      irq_cnt = 0;
      // reset is held for three cycles here
      do_reset;
      // reset values, unmapped place, frozen port
      rd_chk(8'h30, 8'h00);
      rd_chk(8'h31, 8'h00);
      rd_chk(8'h32, 8'h00);
      wr_reg(8'h33, 8'hFF);
      rd_chk(8'h33, 8'h00);
      @(negedge clk);
      ce = 1'b0;
      wr_reg(8'h31, 8'h07);
      ce = 1'b1;
      rd_chk(8'h31, 8'h00);
      // flags are read-only, enables writable
      wr_reg(8'h30, 8'hFC);
      rd_chk(8'h30, 8'h0C);
      // every filter code, unused bits ignored
      for (int c = 0; c < 8; c++)
      begin
         wr_reg(8'h32, {2'b11, 3'(c), 3'b011});
         rd_chk(8'h32, {2'b00, 3'(c), 3'b011});
      end
      // write then read in the very next cycle, read sees new enables
      @(negedge clk);
      reg_addr = 8'h30;
      reg_wdata = 8'h0F;
      reg_wr = 1'b1;
      @(negedge clk);
      reg_wr = 1'b0;
      reg_rd = 1'b1;
      @(negedge clk);
      reg_rd = 1'b0;
      check(reg_rdata, 8'h0F);
      $display("register map done");
      // hysteresis walk on sensor one, then sensor two comparator enables, interrupts on
      do_reset;
      force_chk(0, 8'd0, 2'b11, 4'h5);
      force_chk(0, 8'd45, 2'b11, 4'h5);
      force_chk(0, 8'd55, 2'b11, 4'h5);
      force_chk(0, 8'd130, 2'b11, 4'h5);
      force_chk(0, 8'd150, 2'b11, 4'h5);
      force_chk(1, 8'd60, 2'b01, 4'hA);
      force_chk(1, 8'd10, 2'b10, 4'hA);
      $display("forced conversions done");
      // random lights, enables and interrupt masks
      for (int i = 0; i < 24; i++)
      begin
         seed = xs(seed);
         force_chk(i % 2, seed[7:0], seed[13:12], seed[11:8]);
      end
      $display("random conversions done");
      measure_count_sel_chk(3'h0);
      measure_count_sel_chk(3'h3);
      print_verdict;
   end
endmodule

// *** verification/light_sensor_model.sv ***
// Purpose: two ambient light sensors with their analogue comparators
// Assumes: light is a code, smaller means darker
// Notes:   both sensors share one set of thresholds
`timescale 1ns/1ns
module light_sensor_model
#(
   parameter int DARK_TRIP = 40,   // dark trip code
   parameter int DARK_HYS  = 10,   // dark hysteresis code
   parameter int OFF_TRIP  = 120,  // office trip code
   parameter int OFF_HYS   = 20    // office hysteresis code
)
(
   // light per sensor, sensor two in the upper byte
   input  wire logic [15:0] light,
   // comparator levels, bit 0 is sensor one
   output logic      [1:0]  dark_below,
   output logic      [1:0]  dark_above,
   output logic      [1:0]  off_below,
   output logic      [1:0]  off_above
);
   // ------------------------------------------------------------
   // comparators
   // ------------------------------------------------------------
   // settle at once: the capacitor lag is shorter than one slot
   always_comb
   begin
      for (int s = 0; s < 2; s++)
      begin
         dark_below[s] = int'(light[s*8 +: 8]) < DARK_TRIP;
         dark_above[s] = int'(light[s*8 +: 8]) > DARK_TRIP + DARK_HYS;
         off_below[s]  = int'(light[s*8 +: 8]) < OFF_TRIP;
         off_above[s]  = int'(light[s*8 +: 8]) > OFF_TRIP + OFF_HYS;
      end
   end
endmodule
